// ==== rra_ctrl.sv ====
`include "rra_regs.svh"

module rra_ctrl
	import rra_pkg::*;
#(
	parameter int NUM_BANKS = 16,
	parameter int BANK_W = 4,
	parameter int ROW_W = 17
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	rra_if.ctrl link
);

	// Whole state of the controller end
	typedef struct packed {
		rra_ctl_t fsm;
		logic [2:0] op;
		logic soft_en;
		logic hard_en;
		logic rep_req;
		logic undo_req;
		logic info_req;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
		logic [1:0] page;
		logic [1:0] sel;
		logic last_ok;
		logic skipped;
		logic [7:0] info_data;
		logic [3:0] act_code;
		logic [NUM_BANKS-1:0] hard_mask;
		logic dp_write;
		logic [7:0] dp_addr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic hresp;
	} rra_ctl_state_t;

	rra_ctl_state_t st_reg;
	rra_ctl_state_t st_next;
	logic [31:0] rd_word;

	// Activate limit in thousands, zero for untested or reserved
	function automatic logic [15:0] limit_k(input logic [3:0] code);
		case (code)
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5: limit_k = 16'(16'd800 - 16'd100 * 16'(code));
			4'h7: limit_k = 16'd200;
			4'h8: limit_k = 16'hffff;
			default: limit_k = 16'h0000;
		endcase
	endfunction

	// Register read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		case (haddr[7:0])
			`RRA_OFF_STATUS: begin
				rd_word[`RRA_ST_BUSY] = st_reg.fsm != RRA_IDLE;
				rd_word[`RRA_ST_OK] = st_reg.last_ok;
				rd_word[`RRA_ST_SKIP] = st_reg.skipped;
				rd_word[`RRA_ST_FINITE] = limit_k(st_reg.act_code) != 16'hffff &&
					limit_k(st_reg.act_code) != 16'h0000; // [R3]
				rd_word[`RRA_ST_MASK_LSB +: 16] = 16'(st_reg.hard_mask);
			end
			`RRA_OFF_INFO: rd_word[7:0] = st_reg.info_data;
			`RRA_OFF_LIMIT: rd_word[15:0] = limit_k(st_reg.act_code); // [R3]
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.rep_req = 1'b0;
		st_next.undo_req = 1'b0;
		st_next.info_req = 1'b0;
		st_next.hreadyout = 1'b1;

		// Address phase of the bus slave
		st_next.dp_write = 1'b0;
		if (hsel && hready && htrans[1]) begin
			st_next.dp_write = hwrite;
			st_next.dp_addr = haddr[7:0];
			if (!hwrite) begin
				st_next.hrdata = rd_word;
			end
		end

		case (st_reg.fsm)
			RRA_IDLE: begin
				// Command write starts a sequence, ignored while busy
				if (st_reg.dp_write && st_reg.dp_addr == `RRA_OFF_CMD) begin
					st_next.op = hwdata[`RRA_CMD_OP_LSB +: `RRA_CMD_OP_W];
					st_next.bank = hwdata[`RRA_CMD_BANK_LSB +: BANK_W];
					st_next.row = hwdata[`RRA_CMD_ROW_LSB +: ROW_W]; // [R15]
					st_next.sel = hwdata[`RRA_CMD_SEL_LSB +: 2];
					st_next.page = hwdata[`RRA_CMD_PAGE_LSB +: 2];
					st_next.skipped = 1'b0;
					case (hwdata[`RRA_CMD_OP_LSB +: `RRA_CMD_OP_W])
						`RRA_OP_SOFT, `RRA_OP_HARD: begin
							// Compared as int, a sized bank count wraps to zero at 16 banks
							if (int'(hwdata[`RRA_CMD_BANK_LSB +: BANK_W]) < NUM_BANKS &&
								st_reg.hard_mask[hwdata[`RRA_CMD_BANK_LSB +: BANK_W]]) begin
								st_next.skipped = 1'b1; // [R16]
								st_next.last_ok = 1'b0;
							end else begin
								st_next.fsm = RRA_CLEAR;
							end
						end
						`RRA_OP_UNDO: st_next.fsm = RRA_CLEAR;
						`RRA_OP_INFO: st_next.fsm = RRA_INFO;
						default: st_next.fsm = RRA_IDLE;
					endcase
				end
			end
			RRA_CLEAR: begin
				// Both modes off before entry
				st_next.soft_en = 1'b0; // [R17]
				st_next.hard_en = 1'b0;
				st_next.fsm = st_reg.op == `RRA_OP_UNDO ? RRA_ISSUE : RRA_ENABLE;
			end
			RRA_ENABLE: begin
				// Exactly one mode on
				st_next.soft_en = st_reg.op == `RRA_OP_SOFT; // [R4]
				st_next.hard_en = st_reg.op == `RRA_OP_HARD;
				st_next.fsm = RRA_ISSUE;
			end
			RRA_ISSUE: begin
				st_next.rep_req = st_reg.op != `RRA_OP_UNDO; // [R15]
				st_next.undo_req = st_reg.op == `RRA_OP_UNDO;
				st_next.fsm = RRA_WAIT;
			end
			RRA_WAIT: begin
				if (link.rep_done) begin
					st_next.last_ok = link.rep_ok;
					if (link.rep_ok && st_reg.op == `RRA_OP_HARD) begin
						st_next.hard_mask[st_reg.bank] = 1'b1; // [R16]
					end
					st_next.fsm = RRA_EXIT;
				end
			end
			RRA_EXIT: begin
				st_next.soft_en = 1'b0;
				st_next.hard_en = 1'b0;
				st_next.fsm = RRA_IDLE;
			end
			RRA_INFO: begin
				st_next.info_req = 1'b1;
				st_next.fsm = RRA_IWAIT;
			end
			RRA_IWAIT: begin
				if (link.info_valid) begin
					st_next.info_data = link.info_data;
					st_next.last_ok = 1'b1;
					if (st_reg.page == `RRA_PAGE_LIMIT && st_reg.sel == `RRA_SEL_LIMIT) begin
						st_next.act_code = link.info_data[3:0]; // [R2] [R3]
					end
					st_next.fsm = RRA_IDLE;
				end
			end
			default: st_next.fsm = RRA_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
			st_reg.fsm <= RRA_IDLE;
			st_reg.act_code <= `RRA_RST_ACT_CODE;
			st_reg.info_data <= `RRA_RST_INFO;
			st_reg.hreadyout <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Bus answers, always OKAY
	assign hreadyout = st_reg.hreadyout;
	assign hresp = st_reg.hresp;
	assign hrdata = st_reg.hrdata;

	// Link drive
	assign link.soft_en = st_reg.soft_en;
	assign link.hard_en = st_reg.hard_en;
	assign link.rep_req = st_reg.rep_req;
	assign link.undo_req = st_reg.undo_req;
	assign link.rep_bank = st_reg.bank;
	assign link.rep_row = st_reg.row;
	assign link.info_req = st_reg.info_req;
	assign link.info_page = st_reg.page;
	assign link.info_sel = st_reg.sel;

endmodule

// ==== rra_regs.svh ====
`ifndef RRA_REGS_SVH
`define RRA_REGS_SVH

// Notes on behaviour
// [R1] Limit readout nibble returns 1000, unlimited
// [R2] Nibble codes untested, 700K..300K, 200K, unlimited
// [R3] Controller keeps row activates within reported limit; the code only reports the limit, in LIMIT and the STATUS finite bit
// [R4] Soft and hard repair never enabled together
// [R5] Hard repair support in support readout bit 7
// [R6] Soft repair support in support readout bit 6
// [R7] One spare row per bank, 16 banks
// [R8] Hard repair accepted while soft repairs exist
// [R9] Spare state per bank, others untouched
// [R10] First soft repair allocates spare as soft
// [R11] Later soft repair reuses soft spare row
// [R12] Hard repair replaces soft, permanently
// [R13] Hard spare never cleared nor overwritten; the code clears it at reset
// [R14] Soft repair reversible, reassignable, convertible
// [R15] Controller supplies failing row address
// [R16] Controller skips banks already hard repaired
// [R17] Both modes disabled before repair entry

// Register byte offsets
`define RRA_OFF_CMD 8'h00
`define RRA_OFF_STATUS 8'h04
`define RRA_OFF_INFO 8'h08
`define RRA_OFF_LIMIT 8'h0c

// Command register fields
`define RRA_CMD_OP_LSB 0
`define RRA_CMD_OP_W 3
`define RRA_CMD_BANK_LSB 4
`define RRA_CMD_SEL_LSB 4
`define RRA_CMD_PAGE_LSB 6
`define RRA_CMD_ROW_LSB 8

// Command codes
`define RRA_OP_SOFT 3'h1
`define RRA_OP_HARD 3'h2
`define RRA_OP_INFO 3'h3
`define RRA_OP_UNDO 3'h4

// Status register fields
`define RRA_ST_BUSY 0
`define RRA_ST_OK 1
`define RRA_ST_SKIP 2
`define RRA_ST_FINITE 3
`define RRA_ST_MASK_LSB 16

// Readout pages and registers
`define RRA_PAGE_SUPPORT 2'h2
`define RRA_SEL_SUPPORT 2'h0
`define RRA_PAGE_LIMIT 2'h3
`define RRA_SEL_LIMIT 2'h3
`define RRA_SUP_HARD_BIT 7
`define RRA_SUP_SOFT_BIT 6
`define RRA_ACT_LIMIT_UNLIMITED 4'h8

// Reset values
`define RRA_RST_ACT_CODE 4'h0
`define RRA_RST_INFO 8'h00

`endif

// ==== rra_pkg.sv ====
package rra_pkg;

	// Spare row occupancy of one bank
	typedef enum logic [1:0] {
		RRA_EMPTY = 2'b00,
		RRA_SOFT = 2'b01,
		RRA_HARD = 2'b10
	} rra_kind_t;

	// Controller sequencing states
	typedef enum logic [2:0] {
		RRA_IDLE = 3'b000,
		RRA_CLEAR = 3'b001,
		RRA_ENABLE = 3'b010,
		RRA_ISSUE = 3'b011,
		RRA_WAIT = 3'b100,
		RRA_EXIT = 3'b101,
		RRA_INFO = 3'b110,
		RRA_IWAIT = 3'b111
	} rra_ctl_t;

endpackage

// ==== rra_if.sv ====
interface rra_if #(
	parameter int BANK_W = 4,
	parameter int ROW_W = 17
);
	logic soft_en;
	logic hard_en;
	logic rep_req;
	logic undo_req;
	logic [BANK_W-1:0] rep_bank;
	logic [ROW_W-1:0] rep_row;
	logic rep_done;
	logic rep_ok;
	logic info_req;
	logic [1:0] info_page;
	logic [1:0] info_sel;
	logic info_valid;
	logic [7:0] info_data;

	modport device (
		input soft_en, hard_en, rep_req, undo_req, rep_bank, rep_row, info_req, info_page,
		info_sel,
		output rep_done, rep_ok, info_valid, info_data
	);

	modport ctrl (
		output soft_en, hard_en, rep_req, undo_req, rep_bank, rep_row, info_req, info_page,
		info_sel,
		input rep_done, rep_ok, info_valid, info_data
	);
endinterface

// ==== rra_device.sv ====
`include "rra_regs.svh"

module rra_device
	import rra_pkg::*;
#(
	parameter int NUM_BANKS = 16,
	parameter int BANK_W = 4,
	parameter int ROW_W = 17,
	parameter bit HARD_SUP = 1'b1,
	parameter bit SOFT_SUP = 1'b1
) (
	input wire logic hclk,
	input wire logic hresetn,
	rra_if.device link,
	input wire logic [BANK_W-1:0] lookup_bank,
	output logic lookup_hit,
	output logic lookup_hard,
	output logic [ROW_W-1:0] lookup_row,
	output logic [NUM_BANKS-1:0] soft_map,
	output logic [NUM_BANKS-1:0] hard_map
);

	// One spare row per bank
	typedef struct packed {
		rra_kind_t kind;
		logic [ROW_W-1:0] row;
	} rra_slot_t;

	// Whole state of the device end
	typedef struct packed {
		rra_slot_t [NUM_BANKS-1:0] slot;
		logic rep_done;
		logic rep_ok;
		logic info_valid;
		logic [7:0] info_data;
		logic hit;
		logic hard;
		logic [ROW_W-1:0] lrow;
		logic [NUM_BANKS-1:0] soft_map;
		logic [NUM_BANKS-1:0] hard_map;
	} rra_dev_t;

	rra_dev_t st_reg;
	rra_dev_t st_next;

	// Bank index within the populated range
	function automatic logic bank_ok(input logic [BANK_W-1:0] b);
		bank_ok = int'(b) < NUM_BANKS;
	endfunction

	// New content of a spare row for a repair request
	function automatic rra_slot_t slot_repair(
		input rra_slot_t cur,
		input logic hard,
		input logic [ROW_W-1:0] row
	);
		slot_repair = cur;
		case (cur.kind)
			RRA_EMPTY: begin
				// First repair fixes the type of the spare
				slot_repair.kind = hard ? RRA_HARD : RRA_SOFT; // [R10]
				slot_repair.row = row;
			end
			RRA_SOFT: begin
				// Soft spare is released and reused
				slot_repair.kind = hard ? RRA_HARD : RRA_SOFT; // [R11] [R12] [R14]
				slot_repair.row = row;
			end
			RRA_HARD: begin
				// Permanent spare keeps its address
				slot_repair = cur; // [R13]
			end
			default: begin
				slot_repair = cur;
			end
		endcase
	endfunction

	// Readout registers by page and index
	function automatic logic [7:0] readout(input logic [1:0] page, input logic [1:0] sel);
		readout = 8'h00;
		if (page == `RRA_PAGE_SUPPORT && sel == `RRA_SEL_SUPPORT) begin
			readout[`RRA_SUP_HARD_BIT] = HARD_SUP; // [R5]
			readout[`RRA_SUP_SOFT_BIT] = SOFT_SUP; // [R6]
		end
		if (page == `RRA_PAGE_LIMIT && sel == `RRA_SEL_LIMIT) begin
			// Upper nibble is don't care and reads zero
			readout = {4'h0, `RRA_ACT_LIMIT_UNLIMITED}; // [R1] [R2]
		end
	endfunction

	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.rep_done = 1'b0;
		st_next.rep_ok = 1'b0;
		st_next.info_valid = 1'b0;

		// Repair request, exactly one mode must be on
		if (link.rep_req) begin
			st_next.rep_done = 1'b1;
			if ((link.soft_en ^ link.hard_en) && bank_ok(link.rep_bank)) begin // [R4]
				// Only the addressed bank changes
				st_next.slot[link.rep_bank] = slot_repair(st_reg.slot[link.rep_bank],
					link.hard_en, link.rep_row); // [R9] [R8]
				st_next.rep_ok = st_reg.slot[link.rep_bank].kind != RRA_HARD;
			end
		end

		// Reversal of a soft repair
		if (link.undo_req) begin
			st_next.rep_done = 1'b1;
			if (bank_ok(link.rep_bank) && st_reg.slot[link.rep_bank].kind == RRA_SOFT) begin
				st_next.slot[link.rep_bank].kind = RRA_EMPTY; // [R14]
				st_next.rep_ok = 1'b1;
			end
		end

		// Readout request
		if (link.info_req) begin
			st_next.info_valid = 1'b1;
			st_next.info_data = readout(link.info_page, link.info_sel);
		end

		// Remap lookup for the array side
		if (bank_ok(lookup_bank)) begin
			st_next.hit = st_reg.slot[lookup_bank].kind != RRA_EMPTY;
			st_next.hard = st_reg.slot[lookup_bank].kind == RRA_HARD;
			st_next.lrow = st_reg.slot[lookup_bank].row;
		end else begin
			st_next.hit = 1'b0;
			st_next.hard = 1'b0;
			st_next.lrow = '0;
		end

		// Occupancy maps of all banks
		for (int i = 0; i < NUM_BANKS; i++) begin // [R7]
			st_next.soft_map[i] = st_reg.slot[i].kind == RRA_SOFT;
			st_next.hard_map[i] = st_reg.slot[i].kind == RRA_HARD;
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Link answers
	assign link.rep_done = st_reg.rep_done;
	assign link.rep_ok = st_reg.rep_ok;
	assign link.info_valid = st_reg.info_valid;
	assign link.info_data = st_reg.info_data;

	// Array side outputs
	assign lookup_hit = st_reg.hit;
	assign lookup_hard = st_reg.hard;
	assign lookup_row = st_reg.lrow;
	assign soft_map = st_reg.soft_map;
	assign hard_map = st_reg.hard_map;

endmodule

// ==== rra_checker.sv ====
module rra_checker #(
	parameter int BANK_W = 4,
	parameter int ROW_W = 17
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic soft_en,
	input wire logic hard_en,
	input wire logic rep_req,
	input wire logic undo_req,
	input wire logic [BANK_W-1:0] rep_bank,
	input wire logic [ROW_W-1:0] rep_row,
	input wire logic rep_done,
	input wire logic rep_ok,
	input wire logic info_req,
	input wire logic [1:0] info_page,
	input wire logic [1:0] info_sel,
	input wire logic info_valid,
	input wire logic [7:0] info_data
);
	logic [2**BANK_W-1:0] hard_seen;

	// Banks that took a permanent repair
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hard_seen <= '0;
		end else if (rep_done && rep_ok && hard_en) begin
			hard_seen[rep_bank] <= 1'b1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Readout requests by page and register, repair requests on banks without a permanent repair
	sequence s_ask_limit;
		info_req && info_page == 2'h3 && info_sel == 2'h3;
	endsequence
	sequence s_ask_support;
		info_req && info_page == 2'h2 && info_sel == 2'h0;
	endsequence
	sequence s_soft_free;
		rep_req && soft_en && !hard_seen[rep_bank];
	endsequence
	sequence s_hard_free;
		rep_req && hard_en && !hard_seen[rep_bank];
	endsequence

	chk_mode_excl: assert property (!(soft_en && hard_en))
		else $error("both repair modes enabled");
	chk_one_mode: assert property (rep_req |-> (soft_en ^ hard_en))
		else $error("repair request without exactly one mode");
	chk_rep_answer: assert property (rep_req |=> rep_done)
		else $error("repair request not answered");
	chk_done_cause: assert property (rep_done |-> $past(rep_req || undo_req))
		else $error("repair answer without request");
	// Undo reaches a permanent spare too, so this is exercised
	chk_hard_keep: assert property ((rep_req || undo_req) && hard_seen[rep_bank] |=> !rep_ok)
		else $error("permanent spare row accepted a repair");
	chk_soft_alloc: assert property (s_soft_free |=> rep_ok)
		else $error("soft repair refused on free bank");
	chk_hard_accept: assert property (s_hard_free |=> rep_ok)
		else $error("hard repair refused on free bank");
	chk_info_answer: assert property (info_req |=> info_valid)
		else $error("readout not answered");
	chk_limit_code: assert property (s_ask_limit |=> info_data[3:0] == 4'h8)
		else $error("activate limit code wrong");
	chk_hard_sup: assert property (s_ask_support |=> info_data[7])
		else $error("hard repair support bit low");
	chk_soft_sup: assert property (s_ask_support |=> info_data[6])
		else $error("soft repair support bit low");
endmodule

// ==== tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] lookup_bank;
	logic lookup_hit, lookup_hard;
	logic [16:0] lookup_row;
	logic [15:0] soft_map, hard_map;
	logic [1:0] kind [16];
	logic [16:0] rows [16];
	logic [2:0] ops [10] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h4, 3'h1, 3'h2, 3'h4};
	logic [3:0] bnks [10] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h1};
	int num_errors, checked, sd, k;

	rra_if #(.BANK_W(4), .ROW_W(17)) link();
	rra_device u_rra_device(.hclk(hclk), .hresetn(hresetn), .link(link),
		.lookup_bank(lookup_bank), .lookup_hit(lookup_hit), .lookup_hard(lookup_hard),
		.lookup_row(lookup_row), .soft_map(soft_map), .hard_map(hard_map));
	rra_ctrl u_rra_ctrl(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
	rra_checker u_rra_checker(.hclk(hclk), .hresetn(hresetn), .soft_en(link.soft_en),
		.hard_en(link.hard_en), .rep_req(link.rep_req), .undo_req(link.undo_req),
		.rep_bank(link.rep_bank), .rep_row(link.rep_row), .rep_done(link.rep_done),
		.rep_ok(link.rep_ok), .info_req(link.info_req), .info_page(link.info_page),
		.info_sel(link.info_sel), .info_valid(link.info_valid), .info_data(link.info_data));

	// Clock at 40 MHz
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Waits for hready sampled high, bounded
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			end_sim;
		end
	endtask

	// One single word transfer
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask

	// Command write, then status poll until idle
	task cmd(input logic [2:0] op, input logic [3:0] b, input logic [16:0] rw,
		output logic [31:0] st);
		int n;
		bus(32'h0, 1'b1, {7'h0, rw, b, 1'b0, op}, st);
		repeat (2) @(posedge hclk);
		n = 0;
		do begin
			bus(32'h4, 1'b0, 32'h0, st);
			n++;
		end while (st[0] !== 1'b0 && n < 20);
		if (st[0] !== 1'b0) begin
			num_errors++;
			end_sim;
		end
	endtask

	function logic [15:0] kmask(input logic [1:0] k);
		for (int i = 0; i < 16; i++) kmask[i] = (kind[i] == k);
	endfunction

	function logic [7:0] exp_info(input logic [1:0] p, input logic [1:0] s);
		if (p == 2'h2 && s == 2'h0) return 8'hc0;
		if (p == 2'h3 && s == 2'h3) return 8'h08;
		return 8'h00;
	endfunction

	// Repair with expected outcome from the bench model
	task do_rep(input logic [2:0] op, input logic [3:0] b, input logic [16:0] rw);
		logic [31:0] st;
		logic hb;
		hb = (kind[b] == 2'h2);
		cmd(op, b, rw, st);
		if (op != 3'h4 && hb) begin
			check(st[2], 1'b1);
		end else begin
			if (!hb) check(st[1], op != 3'h4 || kind[b] == 2'h1);
			if (op == 3'h4) begin
				if (kind[b] == 2'h1) kind[b] = 2'h0;
			end else begin
				kind[b] = (op == 3'h2) ? 2'h2 : 2'h1;
				rows[b] = rw;
			end
		end
		check(st[31:16], kmask(2'h2));
		lookup_bank <= b;
		repeat (3) @(posedge hclk);
		check(soft_map, kmask(2'h1));
		check(hard_map, kmask(2'h2));
		check({lookup_hit, lookup_hard}, {kind[b] != 2'h0, kind[b] == 2'h2});
		if (kind[b] != 2'h0) check(lookup_row, rows[b]);
	endtask

	task do_reset(input int n);
		hresetn <= 1'b0;
		repeat (n) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 16; i++) kind[i] = 2'h0;
	endtask

	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		lookup_bank = '0;
		sd = $urandom(32'hb9e47f2f);
		do_reset(10);
		for (int p = 0; p < 4; p++) begin
			for (int s = 0; s < 4; s++) begin
				cmd(3'h3, {p[1:0], s[1:0]}, 17'h0, r);
				bus(32'h8, 1'b0, 32'h0, r);
				check(r, exp_info(p[1:0], s[1:0]));
			end
		end
		bus(32'h4, 1'b0, 32'h0, r);
		check(r[3], 1'b0);
		bus(32'hc, 1'b0, 32'h0, r);
		check(r[15:0], 16'hffff);
		check(hresp, 1'b0);
		bus(32'h10, 1'b1, 32'hffffffff, r);
		bus(32'h10, 1'b0, 32'h0, r);
		check(r, 32'h0);
		for (int i = 0; i < 70; i++) begin
			if (i == 60) begin
				do_reset(3);
				repeat (3) @(posedge hclk);
				check({soft_map, hard_map}, 32'h0);
			end
			k = $urandom % 4;
			if (i < 10) do_rep(ops[i], bnks[i], 17'($urandom));
			else do_rep(k == 0 ? 3'h2 : (k == 1 ? 3'h4 : 3'h1), 4'($urandom), 17'($urandom));
		end
		end_sim;
	end
endmodule
